//--- emc_map.svh
// Constants for the external memory select and clock-out block.
// Assumes inclusion by bare name from the block's package and modules.
`ifndef EMC_MAP_SVH
`define EMC_MAP_SVH
// ****************************************
// Address fields
// ****************************************
`define EMC_SPACE_MSB   31
`define EMC_SPACE_LSB   28
`define EMC_LANE_MSB    1
`define EMC_LANE_LSB    0
`define EMC_NUM_SPACES  4
// ****************************************
// Reset values of the clock controls
// ****************************************
`define EMC_SRC_RST     1'h0
`define EMC_EN_RST      1'h1
`endif

//--- emc_pkg.sv
// Types for the external memory select and clock-out block.
// Assumes emc_map.svh is reachable on the include path.
`include "emc_map.svh"
package emc_pkg;
   // Arbitration states of the bus-hold handshake
   typedef enum logic [1:0] {EMC_OWN, EMC_GRANT} emc_hold_t;
   typedef logic [`EMC_NUM_SPACES-1:0] emc_sel_t;
endpackage

//--- emc_clk_if.sv
// Interface between the top and the clock-out generator.
// Assumes both ends run on clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
interface emc_clk_if;
   logic src_sel;   // 0 third system clock, 1 interface clock
   logic out_en;    // 0 hold low
   logic sys3_s;    // Synchronised third system clock level
   logic ext_s;     // Synchronised interface clock level
   logic clk_out;   // Generated output clock
   modport top (output src_sel, out_en, sys3_s, ext_s, input clk_out);
   modport gen (input src_sel, out_en, sys3_s, ext_s, output clk_out);
endinterface
`default_nettype wire

//--- emc_clk_gen.sv
// Clock-out generator: picks the source level and gates it low.
// Assumes source levels are already synchronised to clk_sys_i.
`timescale 1ns/1ps
`default_nettype none
module emc_clk_gen
   import emc_pkg::*;
(
   input  wire logic clk_sys_i, // System clock
   input  wire logic rst_i,     // Synchronous reset
   emc_clk_if.gen    cif        // Clock controls and result
);
   logic clk_q;
   logic next_clk_q;

   // Mux then gate; gating at the flop avoids a combinational glitch on the pin
   always_comb
   begin
      next_clk_q = cif.src_sel ? cif.ext_s : cif.sys3_s;
      if (!cif.out_en)
      begin
         next_clk_q = 1'h0;
      end
   end

   // Register the clock level
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         clk_q <= 1'h0;
      end
      else
      begin
         clk_q <= next_clk_q;
      end
   end

   assign cif.clk_out = clk_q;

   chk_gate_holds_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !cif.out_en |=> !clk_q)
      else $error("clock out not low when gated");
endmodule // emc_clk_gen
`default_nettype wire

//--- emc_sel_top.sv
// External memory selects, byte lanes, bus hold and clock out.
// Assumes access requests come from logic on clk_sys_i; pins are asynchronous.
// Operation
// - Select space from word address bits 28-31
// - At most one select asserted per access; space codes above 3 select none
// - Byte lanes decoded from the lowest address bit
// - Byte lanes double as SDRAM data mask
// - Host hold request answered by hold acknowledge
// - Source bit picks system or interface clock
// - Enable bit low holds clock output low
`timescale 1ns/1ps
`default_nettype none
module emc_sel_top
   import emc_pkg::*;
(
   input  wire logic        clk_sys_i,           // 200 MHz system clock
   input  wire logic        rst_i,               // Synchronous reset, active high
   input  wire logic        acc_valid_i,         // Access in progress (same domain)
   input  wire logic [31:0] acc_word_addr_i,     // Word address of access
   input  wire logic [1:0]  acc_byte_addr_i,     // Low bits of byte address
   input  wire logic        bus_hold_req_i,      // Host hold request (pin)
   input  wire logic        system_clock_third_i,// Third system clock level (pin)
   input  wire logic        iface_clock_in_i,    // Interface clock input (pin)
   input  wire logic        clock_out_source_sel_i, // 0 system, 1 interface clock
   input  wire logic        clock_out_enable_i,  // 0 holds clock low
   output logic [3:0]       mem_space_select_n_o,  // Selects, active low
   output logic [3:0]       mem_space_select_oe_n_o, // Select drive, low drives
   output logic             byte_lane_enable_hi_n_o, // Upper lane, active low
   output logic             byte_lane_enable_lo_n_o, // Lower lane, active low
   output logic             byte_lane_oe_n_o,    // Lane drive, low drives
   output logic             bus_hold_ack_o,      // Hold acknowledge to host
   output logic             bus_grant_idle_o,    // High when no access pending
   output logic             iface_clock_out_o    // Interface output clock
);
   // ****************************************
   // Pin synchronisers
   // ****************************************
   logic [2:0] sync1;
   logic [2:0] sync2;
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         sync1 <= 3'h0;
         sync2 <= 3'h0;
      end
      else
      begin
         sync1 <= {bus_hold_req_i, iface_clock_in_i, system_clock_third_i};
         sync2 <= sync1;
      end
   end

   // Control bits held in flops; the reset values are the documented defaults
   logic src_sel;
   logic out_en;
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         src_sel <= `EMC_SRC_RST;
         out_en  <= `EMC_EN_RST;
      end
      else
      begin
         src_sel <= clock_out_source_sel_i;
         out_en  <= clock_out_enable_i;
      end
   end

   // ****************************************
   // Hold arbitration
   // ****************************************
   emc_hold_t hold_st;
   emc_hold_t next_hold_st;
   // Grant only between accesses, so a select never drops mid-cycle
   always_comb
   begin
      next_hold_st = hold_st;
      unique case (hold_st)
         EMC_OWN:   if (sync2[2] && !acc_valid_i) next_hold_st = EMC_GRANT;
         EMC_GRANT: if (!sync2[2]) next_hold_st = EMC_OWN;
      endcase
   end
   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         hold_st <= EMC_OWN;
      end
      else
      begin
         hold_st <= next_hold_st;
      end
   end

   // ****************************************
   // Select and lane decode
   // ****************************************
   emc_sel_t   next_sel_n;
   logic [1:0] next_lane_n;
   logic       drive;
   assign drive = (next_hold_st == EMC_OWN);
   // One-hot decode of the space field; space codes above 3 select nothing
   always_comb
   begin
      next_sel_n  = '1;
      next_lane_n = 2'h3;
      if (acc_valid_i && drive)
      begin
         for (int i = 0; i < `EMC_NUM_SPACES; i++)
         begin
            if (acc_word_addr_i[`EMC_SPACE_MSB:`EMC_SPACE_LSB] == 4'(i))
            begin
               next_sel_n[i] = 1'h0;
            end
         end
         // Same strobe serves as write enable and SDRAM mask
         next_lane_n[1] = ~acc_byte_addr_i[`EMC_LANE_LSB];
         next_lane_n[0] = acc_byte_addr_i[`EMC_LANE_LSB];
      end
   end

   always_ff @(posedge clk_sys_i)
   begin
      if (rst_i)
      begin
         mem_space_select_n_o    <= 4'hF;
         mem_space_select_oe_n_o <= 4'h0;
         byte_lane_enable_hi_n_o <= 1'h1;
         byte_lane_enable_lo_n_o <= 1'h1;
         byte_lane_oe_n_o        <= 1'h0;
         bus_hold_ack_o          <= 1'h0;
         bus_grant_idle_o        <= 1'h1;
      end
      else
      begin
         mem_space_select_n_o    <= next_sel_n;
         mem_space_select_oe_n_o <= {4{~drive}};
         byte_lane_enable_hi_n_o <= next_lane_n[1];
         byte_lane_enable_lo_n_o <= next_lane_n[0];
         byte_lane_oe_n_o        <= ~drive;
         bus_hold_ack_o          <= (next_hold_st == EMC_GRANT);
         bus_grant_idle_o        <= ~acc_valid_i;
      end
   end

   // ****************************************
   // Clock out
   // ****************************************
   emc_clk_if cif ();
   assign cif.src_sel = src_sel;
   assign cif.out_en  = out_en;
   assign cif.sys3_s  = sync2[0];
   assign cif.ext_s   = sync2[1];
   emc_clk_gen u_gen (
      .clk_sys_i (clk_sys_i),
      .rst_i     (rst_i),
      .cif       (cif)
   );
   assign iface_clock_out_o = cif.clk_out;

   // ****************************************
   // Checks
   // ****************************************
   // Steps of the hold handshake, as the host sees them on the pins
   sequence seq_hold_seen;
      sync2[2] && !acc_valid_i && (hold_st == EMC_OWN);
   endsequence
   sequence seq_bus_released;
      bus_hold_ack_o && (mem_space_select_oe_n_o == '1) && byte_lane_oe_n_o;
   endsequence
   sequence seq_hold_dropped;
      !sync2[2] && (hold_st == EMC_GRANT);
   endsequence
   sequence seq_bus_retaken;
      !bus_hold_ack_o && (mem_space_select_oe_n_o == '0) && !byte_lane_oe_n_o;
   endsequence

   // Decode: at most one select, none without an access, and space 2 selected when addressed
   chk_one_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      $countones(~mem_space_select_n_o) <= 1)
      else $error("more than one select");
   chk_idle_no_select: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      !acc_valid_i |=> (mem_space_select_n_o == '1))
      else $error("select without an access");
   chk_select_decode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (acc_valid_i && hold_st == EMC_OWN && !sync2[2]
         && acc_word_addr_i[`EMC_SPACE_MSB:`EMC_SPACE_LSB] == 4'h2)
      |=> !mem_space_select_n_o[2])
      else $error("space 2 not selected");

   // Lanes: one strobe low per access, picked by the low address bit
   chk_lane_decode: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (acc_valid_i && hold_st == EMC_OWN && !sync2[2])
      |=> byte_lane_enable_lo_n_o == $past(acc_byte_addr_i[`EMC_LANE_LSB]))
      else $error("lane wrong");
   chk_lane_one_low: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (acc_valid_i && hold_st == EMC_OWN && !sync2[2])
      |=> (byte_lane_enable_hi_n_o != byte_lane_enable_lo_n_o))
      else $error("lane strobes not one low");

   // Hold: answer only between accesses, free the pins, take them back after
   chk_hold_answer: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (sync2[2] && !acc_valid_i && hold_st == EMC_OWN) |=> bus_hold_ack_o)
      else $error("hold not acked");
   chk_hold_waits: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (acc_valid_i && hold_st == EMC_OWN) |=> !bus_hold_ack_o)
      else $error("hold granted mid access");
   chk_hold_grant_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      seq_hold_seen |=> seq_bus_released)
      else $error("pins kept on grant");
   chk_hold_release_seq: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      seq_hold_dropped |=> seq_bus_retaken)
      else $error("pins not retaken after hold");
   chk_hold_float: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      bus_hold_ack_o |-> (mem_space_select_oe_n_o == 4'hF) && byte_lane_oe_n_o)
      else $error("driving in hold");
   chk_hold_inactive: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      bus_hold_ack_o |-> (mem_space_select_n_o == '1) && byte_lane_enable_hi_n_o && byte_lane_enable_lo_n_o)
      else $error("strobe active in hold");

   // Clock out: follows the chosen synchronised source one edge later
   chk_src_ext: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (src_sel && out_en) |=> iface_clock_out_o == $past(sync2[1]))
      else $error("wrong clock source");
   chk_src_sys: assert property (@(posedge clk_sys_i) disable iff (rst_i)
      (!src_sel && out_en) |=> iface_clock_out_o == $past(sync2[0]))
      else $error("system clock not followed");
endmodule // emc_sel_top
`default_nettype wire

//--- emc_far_side.sv
// Far-side model: bus-hold host, pulled-up memory pins, interface clock.
// Assumes the bench changes want_hold_i just after clk_sys_i edges.
`timescale 1ns/1ps
`default_nettype none
module emc_far_side
(
   input  wire logic       clk_sys_i,   // System clock
   input  wire logic       want_hold_i, // Host wants the bus
   input  wire logic       hold_ack_i,  // Acknowledge from device
   input  wire logic [3:0] sel_n_i,     // Select pins as driven
   input  wire logic [3:0] sel_oe_n_i,  // Select drive, low drives
   input  wire logic [1:0] lane_n_i,    // Upper, lower lane as driven
   input  wire logic       lane_oe_n_i, // Lane drive, low drives
   output logic            hold_req_o,  // Hold request pin
   output logic            iface_clk_o, // Interface clock pin
   output logic [3:0]      sel_pin_o,   // Resolved select pins
   output logic [1:0]      lane_pin_o   // Resolved lane pins
);
   // ****************************************
   // Host and pins
   // ****************************************
   // Request is never dropped before it was acknowledged; an unknown
   // power-up level counts as idle so the pin never stays unknown
   always_ff @(posedge clk_sys_i)
   begin
      if (hold_req_o === 1'b1)
      begin
         hold_req_o <= want_hold_i | ~hold_ack_i;
      end
      else
      begin
         hold_req_o <= want_hold_i;
      end
   end
   // Released pins float up to the pull-up level
   assign sel_pin_o  = sel_n_i | sel_oe_n_i;
   assign lane_pin_o = lane_n_i | {2{lane_oe_n_i}};
   // Free-running oscillator, phase kept off the system clock edges
   initial
   begin
      iface_clk_o = 1'b0;
      #2.3;
      forever #40 iface_clk_o = ~iface_clk_o;
   end
endmodule // emc_far_side
`default_nettype wire

//--- testbench.sv
// Self-checking bench for the memory select and clock-out block.
// Assumes the package, design and far-side model are compiled first.
`timescale 1ns/1ps
`default_nettype none
module testbench;
   logic        clk_sys_i, rst_i, acc_valid, sys3, want, src_sel, out_en;
   logic        hi_n, lo_n, lane_oe_n, ack, idle, ck_out, hold_req, ext_ck;
   logic [31:0] addr;
   logic [1:0]  byte_a, lane_pin;
   logic [3:0]  sel_n, sel_oe_n, sel_pin;
   logic [2:0]  h_sys, h_ext;
   logic [15:0] lfsr = 16'h001F;
   int          bad_count = 0, checks_done = 0, cyc = 0, n;
   emc_sel_top u_emc_sel_top (.clk_sys_i(clk_sys_i), .rst_i(rst_i), .acc_valid_i(acc_valid),
      .acc_word_addr_i(addr), .acc_byte_addr_i(byte_a), .bus_hold_req_i(hold_req),
      .system_clock_third_i(sys3), .iface_clock_in_i(ext_ck), .clock_out_source_sel_i(src_sel),
      .clock_out_enable_i(out_en), .mem_space_select_n_o(sel_n), .mem_space_select_oe_n_o(sel_oe_n),
      .byte_lane_enable_hi_n_o(hi_n), .byte_lane_enable_lo_n_o(lo_n), .byte_lane_oe_n_o(lane_oe_n),
      .bus_hold_ack_o(ack), .bus_grant_idle_o(idle), .iface_clock_out_o(ck_out));
   emc_far_side u_emc_far_side (.clk_sys_i(clk_sys_i), .want_hold_i(want), .hold_ack_i(ack),
      .sel_n_i(sel_n), .sel_oe_n_i(sel_oe_n), .lane_n_i({hi_n, lo_n}), .lane_oe_n_i(lane_oe_n),
      .hold_req_o(hold_req), .iface_clk_o(ext_ck), .sel_pin_o(sel_pin), .lane_pin_o(lane_pin));
   // ****************************************
   // Clocks, history and helpers
   // ****************************************
   // System clock at 200 MHz
   initial
   begin
      clk_sys_i = 1'b0;
      forever #2.5 clk_sys_i = ~clk_sys_i;
   end
   // Third system clock, offset so no edge meets clk_sys_i
   initial
   begin
      sys3 = 1'b0;
      #1.7;
      forever #10 sys3 = ~sys3;
   end
   // Source levels seen at past edges; a stuck run ends here
   always @(posedge clk_sys_i)
   begin
      h_sys <= {h_sys[1:0], sys3};
      h_ext <= {h_ext[1:0], ext_ck};
      cyc = cyc + 1;
      if (cyc == 6000)
      begin
         bad_count = bad_count + 1;
         wrap_up();
      end
   end
   function automatic logic [15:0] lfsr_next(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   // Expected selects then upper and lower lane, all active low
   function automatic logic [5:0] exp_acc(input logic [3:0] nib, input logic b0);
      return {(nib < 4'h4) ? ~(4'h1 << nib) : 4'hF, ~b0, b0};
   endfunction
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      checks_done = checks_done + 1;
      if (got !== exp)
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      if (got !== exp)
         bad_count = bad_count + 1;
   endtask
   task automatic tick();
      @(posedge clk_sys_i);
      #1;
   endtask
   // Drive one access at an edge, then look once it has been registered
   task automatic access(input logic v, input logic [31:0] a, input logic [1:0] b);
      @(posedge clk_sys_i);
      acc_valid <= v;
      addr      <= a;
      byte_a    <= b;
      tick();
   endtask
   task automatic wrap_up();
      $display("Checks %0d, mismatches %0d", checks_done, bad_count);
      if (bad_count == 0 && checks_done > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   // ****************************************
   // Sequence
   // ****************************************
   initial
   begin
      {rst_i, acc_valid, addr, byte_a, want, src_sel, out_en} = {36'h8_0000_0000, 3'h1};
      repeat (5) @(posedge clk_sys_i);
      rst_i <= 1'b0;
      #1;
      chk({sel_n, sel_oe_n, hi_n, lo_n, lane_oe_n, ack, idle, ck_out}, 16'h3C32);
      // First sixteen drive every space code, codes 4, 9 and 14 with no access; the rest are random
      for (int i = 0; i < 48; i++)
      begin
         lfsr = lfsr_next(lfsr);
         access(i % 5 != 4, {(i < 16) ? i[3:0] : lfsr[3:0], lfsr[11:0], lfsr}, lfsr[5:4]);
         chk({sel_oe_n, idle, sel_n, hi_n, lo_n, lane_oe_n}, {4'h0, ~acc_valid,
            acc_valid ? exp_acc(addr[31:28], byte_a[0]) : 6'h3F, 1'b0});
      end
      $display("Access test done");
      access(1'b0, 32'h0, 2'h0);
      want <= 1'b1;
      for (n = 0; ack !== 1'b1 && n < 8; n++)
         tick();
      chk({ack, sel_oe_n, lane_oe_n, sel_pin, lane_pin}, 16'h0FFF);
      access(1'b1, 32'h1000_0000, 2'h1);
      chk({ack, sel_pin, lane_pin}, 16'h007F);
      access(1'b0, 32'h0, 2'h0);
      want <= 1'b0;
      for (n = 0; ack !== 1'b0 && n < 8; n++)
         tick();
      tick();
      chk({ack, sel_oe_n, lane_oe_n}, 16'h0000);
      $display("Hold test done");
      for (int m = 0; m < 4; m++)
      begin
         @(posedge clk_sys_i);
         src_sel <= m[0];
         out_en  <= m[1];
         repeat (8) tick();
         repeat (60)
         begin
            tick();
            chk(ck_out, m[1] ? (m[0] ? h_ext[2] : h_sys[2]) : 1'b0);
         end
         $display("Clock mode %0d done", m);
      end
      wrap_up();
   end
endmodule // testbench
`default_nettype wire
